/* File: include/rscd_pkg.sv */
// constants and types for the reset strap capture and decode block
package rscd_pkg;

    // sensed pull state on the two mode-select pins
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_UP_10K = 2'h1;
    localparam logic [1:0] PULL_DOWN = 2'h2;

    // sensed five-level resistor strap codes
    localparam logic [2:0] LVL_PD_200K = 3'h0;
    localparam logic [2:0] LVL_PU_200K = 3'h1;
    localparam logic [2:0] LVL_PD_10K = 3'h2;
    localparam logic [2:0] LVL_PU_10K = 3'h3;
    localparam logic [2:0] LVL_PD_10R = 3'h4;

    // port masks, bit 0 is port 1
    localparam logic [3:0] MASK_NONE = 4'h0;
    localparam logic [3:0] MASK_P1 = 4'h1;
    localparam logic [3:0] MASK_P12 = 4'h3;
    localparam logic [3:0] MASK_P123 = 4'h7;
    localparam logic [3:0] MASK_ALL = 4'hf;

    // synchroniser and settle timing
    localparam int SYNC_W = 21;
    localparam logic [1:0] SETTLE_LAST = 2'h2;

    // rom signature check
    localparam logic [7:0] ROM_READ_CMD = 8'h03;
    localparam logic [23:0] ROM_SIG_ADDR = 24'h00fffa;
    localparam logic [31:0] ROM_SIG_WORD = 32'h32444655;
    localparam logic [5:0] ROM_LAST_BIT = 6'h3f;
    localparam int ROM_HALF_CYC = 4;

    // boot stage reported to the rest of the hub
    localparam logic [1:0] STAGE_STRAP = 2'h0;
    localparam logic [1:0] STAGE_ROM_CHECK = 2'h1;
    localparam logic [1:0] STAGE_OTP_CFG = 2'h2;
    localparam logic [1:0] STAGE_HOST_CFG = 2'h3;

    typedef enum logic [2:0] {
        RSCD_ST_SETTLE,
        RSCD_ST_LATCH,
        RSCD_ST_SIG,
        RSCD_ST_OTP,
        RSCD_ST_HOST
    } rscd_state_t;

endpackage

/* File: hw/rscd_sync.sv */
// two-flop synchroniser for pin and strap inputs
`timescale 1ns/1ps
module rscd_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule // rscd_sync

/* File: hw/rscd_top.sv */
// strap capture, mode select, pin mux and strap decode at reset release
// Functional notes
// - latch disable straps when reset releases, fixed and charging straps in host mode only
// - both pins pulled up selects host bus
// - no pulls on both pins selects rom
// - rom used only with valid signature
// - shared pins follow the selected mode
// - disable strap one means off, zero on
// - port off only when both straps high
// - usb2 port off also disables superspeed
// - fixed port strap decodes to port masks
// - charging strap decodes to port masks
// - host bus to host stage, else rom check stage then otp
`timescale 1ns/1ps
module rscd_top #(
    parameter int HALF_CYC = rscd_pkg::ROM_HALF_CYC
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // sensed straps
    input wire logic [1:0] data_pull_i,
    input wire logic [1:0] clock_pull_i,
    input wire logic [2:0] fixed_port_count_strap_i,
    input wire logic [2:0] charging_ports_strap_i,
    input wire logic [3:0] port_plus_line_off_strap_i,
    input wire logic [3:0] port_minus_line_off_strap_i,
    // shared pins
    input wire logic rom_serial_in_pin_i,
    output logic rom_select_pin_o,
    output logic rom_select_pin_oen_o,
    input wire logic host_cfg_data_pin_i,
    output logic host_cfg_data_pin_o,
    output logic host_cfg_data_pin_oen_o,
    input wire logic host_cfg_clock_pin_i,
    output logic host_cfg_clock_pin_o,
    output logic host_cfg_clock_pin_oen_o,
    // host bus slave side
    input wire logic host_data_low_i,
    input wire logic host_clock_low_i,
    output logic host_data_o,
    output logic host_clock_o,
    // decoded results
    output logic strap_done_o,
    output logic host_mode_o,
    output logic rom_enable_o,
    output logic [1:0] stage_o,
    output logic [3:0] plus_off_o,
    output logic [3:0] minus_off_o,
    output logic [3:0] port_off_o,
    output logic [3:0] ss_port_off_o,
    output logic [3:0] fixed_ports_o,
    output logic [3:0] charge_ports_o
);

    typedef struct packed {
        rscd_pkg::rscd_state_t st;
        logic [1:0] settle;
        logic [7:0] half;
        logic [5:0] bits;
        logic [63:0] shreg;
        logic miso_cap;
        logic sclk;
        logic done;
        logic host;
        logic rom_en;
        logic [1:0] stage;
        logic [3:0] plus_off;
        logic [3:0] minus_off;
        logic [3:0] port_off;
        logic [3:0] ss_off;
        logic [3:0] fixed;
        logic [3:0] charge;
        logic cs_o;
        logic cs_oen;
        logic dat_o;
        logic dat_oen;
        logic clk_o;
        logic clk_oen;
        logic hdat;
        logic hclk;
    } rscd_regs_t;

    rscd_regs_t q;
    rscd_regs_t d;
    logic [rscd_pkg::SYNC_W-1:0] sync_s;
    logic miso_s;
    logic dat_s;
    logic clk_s;
    logic [1:0] dpull_s;
    logic [1:0] cpull_s;
    logic [2:0] fixed_s;
    logic [2:0] charge_s;
    logic [3:0] plus_s;
    logic [3:0] minus_s;
    logic sel_host;

    // level code to low-ports-first mask
    function automatic logic [3:0] lvl_to_mask(input logic [2:0] code);
        if (code == rscd_pkg::LVL_PU_200K) begin
            lvl_to_mask = rscd_pkg::MASK_P1;
        end else if (code == rscd_pkg::LVL_PD_10K) begin
            lvl_to_mask = rscd_pkg::MASK_P12;
        end else if (code == rscd_pkg::LVL_PU_10K) begin
            lvl_to_mask = rscd_pkg::MASK_P123;
        end else if (code == rscd_pkg::LVL_PD_10R) begin
            lvl_to_mask = rscd_pkg::MASK_ALL;
        end else begin
            lvl_to_mask = rscd_pkg::MASK_NONE;
        end
    endfunction

    rscd_sync #(
        .WIDTH(rscd_pkg::SYNC_W)
    ) u_sync (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .async_i({rom_serial_in_pin_i, host_cfg_data_pin_i, host_cfg_clock_pin_i,
                  data_pull_i, clock_pull_i, fixed_port_count_strap_i,
                  charging_ports_strap_i, port_plus_line_off_strap_i,
                  port_minus_line_off_strap_i}),
        .sync_o(sync_s)
    );

    assign {miso_s, dat_s, clk_s, dpull_s, cpull_s, fixed_s, charge_s, plus_s, minus_s} = sync_s;
    assign sel_host = (dpull_s == rscd_pkg::PULL_UP_10K) &&
                      (cpull_s == rscd_pkg::PULL_UP_10K);

    always_comb begin
        d = q;
        case (q.st)
            rscd_pkg::RSCD_ST_SETTLE: begin
                // let the synchronisers fill after release
                if (q.settle == rscd_pkg::SETTLE_LAST) begin
                    d.st = rscd_pkg::RSCD_ST_LATCH;
                end else begin
                    d.settle = q.settle + 2'h1;
                end
            end
            rscd_pkg::RSCD_ST_LATCH: begin
                d.done = 1'b1;
                d.plus_off = plus_s;
                d.minus_off = minus_s;
                d.port_off = plus_s & minus_s;
                d.ss_off = plus_s & minus_s;
                d.host = sel_host;
                if (sel_host) begin
                    // straps on pins 41/40 only exist in host mode
                    d.fixed = lvl_to_mask(fixed_s);
                    d.charge = lvl_to_mask(charge_s);
                    d.st = rscd_pkg::RSCD_ST_HOST;
                    d.stage = rscd_pkg::STAGE_HOST_CFG;
                end else begin
                    d.st = rscd_pkg::RSCD_ST_SIG;
                    d.stage = rscd_pkg::STAGE_ROM_CHECK;
                    d.shreg = {rscd_pkg::ROM_READ_CMD, rscd_pkg::ROM_SIG_ADDR, 32'h0000_0000};
                    d.cs_o = 1'b0;
                    d.cs_oen = 1'b0;
                    d.dat_o = rscd_pkg::ROM_READ_CMD[7];
                    d.dat_oen = 1'b0;
                    d.clk_o = 1'b0;
                    d.clk_oen = 1'b0;
                    d.half = 8'h00;
                    d.bits = 6'h00;
                    d.sclk = 1'b0;
                end
            end
            rscd_pkg::RSCD_ST_SIG: begin
                // mode 0 read of the signature word
                if (q.half == 8'(HALF_CYC - 1)) begin
                    d.half = 8'h00;
                    d.sclk = ~q.sclk;
                    d.clk_o = ~q.sclk;
                    if (!q.sclk) begin
                        d.miso_cap = miso_s;
                    end else begin
                        d.shreg = {q.shreg[62:0], q.miso_cap};
                        d.dat_o = q.shreg[62];
                        d.bits = q.bits + 6'h01;
                        if (q.bits == rscd_pkg::ROM_LAST_BIT) begin
                            d.rom_en = ({q.shreg[30:0], q.miso_cap} ==
                                        rscd_pkg::ROM_SIG_WORD);
                            d.cs_o = 1'b1;
                            d.dat_o = 1'b0;
                            d.st = rscd_pkg::RSCD_ST_OTP;
                            d.stage = rscd_pkg::STAGE_OTP_CFG;
                        end
                    end
                end else begin
                    d.half = q.half + 8'h01;
                end
            end
            rscd_pkg::RSCD_ST_HOST: begin
                // open-drain host bus on pins 39/38
                d.dat_o = 1'b0;
                d.dat_oen = ~host_data_low_i;
                d.clk_o = 1'b0;
                d.clk_oen = ~host_clock_low_i;
                d.hdat = dat_s;
                d.hclk = clk_s;
            end
            default: begin
                // results held until the next reset
                d = q;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.st <= rscd_pkg::RSCD_ST_SETTLE;
            q.stage <= rscd_pkg::STAGE_STRAP;
            q.cs_o <= 1'b1;
            q.cs_oen <= 1'b1;
            q.dat_oen <= 1'b1;
            q.clk_oen <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign rom_select_pin_o = q.cs_o;
    assign rom_select_pin_oen_o = q.cs_oen;
    assign host_cfg_data_pin_o = q.dat_o;
    assign host_cfg_data_pin_oen_o = q.dat_oen;
    assign host_cfg_clock_pin_o = q.clk_o;
    assign host_cfg_clock_pin_oen_o = q.clk_oen;
    assign host_data_o = q.hdat;
    assign host_clock_o = q.hclk;
    assign strap_done_o = q.done;
    assign host_mode_o = q.host;
    assign rom_enable_o = q.rom_en;
    assign stage_o = q.stage;
    assign plus_off_o = q.plus_off;
    assign minus_off_o = q.minus_off;
    assign port_off_o = q.port_off;
    assign ss_port_off_o = q.ss_off;
    assign fixed_ports_o = q.fixed;
    assign charge_ports_o = q.charge;

    // checks
    localparam int SIG_MAX = 600;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_latch_host;
        q.st == rscd_pkg::RSCD_ST_LATCH && sel_host;
    endsequence

    sequence s_latch_rom;
        q.st == rscd_pkg::RSCD_ST_LATCH && !sel_host;
    endsequence

    AST_HOLD: assert property (strap_done_o && $past(strap_done_o) |->
        $stable(port_off_o) && $stable(fixed_ports_o) && $stable(charge_ports_o) &&
        $stable(host_mode_o))
        else $error("strap results changed after latch");

    AST_HOST_SEL: assert property (s_latch_host |=> host_mode_o && strap_done_o)
        else $error("host mode not selected");

    AST_ROM_SEL: assert property (q.st == rscd_pkg::RSCD_ST_LATCH &&
        dpull_s == rscd_pkg::PULL_NONE && cpull_s == rscd_pkg::PULL_NONE |=>
        !host_mode_o && !rom_select_pin_o && !rom_select_pin_oen_o)
        else $error("rom mode not selected");

    AST_ROM_CHECK: assert property (s_latch_rom |=> ##[1:SIG_MAX]
        (stage_o == rscd_pkg::STAGE_OTP_CFG && rom_select_pin_o))
        else $error("signature check did not finish");

    AST_ROM_EN: assert property ($rose(rom_enable_o) |->
        $past(q.st) == rscd_pkg::RSCD_ST_SIG && !host_mode_o)
        else $error("rom enabled without check");

    AST_PIN_MUX: assert property (host_mode_o |-> rom_select_pin_oen_o &&
        !host_cfg_data_pin_o && !host_cfg_clock_pin_o)
        else $error("pins not in host mode");

    AST_DIS_DEC: assert property (q.st == rscd_pkg::RSCD_ST_LATCH |=>
        plus_off_o == $past(plus_s) && minus_off_o == $past(minus_s))
        else $error("disable strap decode wrong");

    AST_BOTH_OFF: assert property (strap_done_o |->
        port_off_o == (plus_off_o & minus_off_o) && ss_port_off_o == port_off_o)
        else $error("port disable combine wrong");

    AST_FIXED: assert property ((s_latch_host and
        (fixed_s == rscd_pkg::LVL_PU_10K)) |=> fixed_ports_o == 4'h7)
        else $error("fixed port decode wrong");

    AST_CHARGE: assert property ((s_latch_host and
        (charge_s == rscd_pkg::LVL_PD_10R)) |=> charge_ports_o == 4'hf)
        else $error("charging decode wrong");

    AST_UNDEF: assert property ((s_latch_host and
        (charge_s > rscd_pkg::LVL_PD_10R)) |=> charge_ports_o == 4'h0)
        else $error("undefined code not least enabling");

    AST_STAGE: assert property (s_latch_host |=> stage_o == rscd_pkg::STAGE_HOST_CFG)
        else $error("host stage not entered");

    AST_DEFAULT: assert property (!strap_done_o |-> port_off_o == 4'h0 &&
        fixed_ports_o == 4'h0 && charge_ports_o == 4'h0 && !rom_enable_o)
        else $error("results not at default before latch");

endmodule // rscd_top

/* File: dv/rscd_rom_model.sv */
// serial rom model answering the signature read
`timescale 1ns/1ps
module rscd_rom_model (
    // rom pins
    input wire logic cs_n_i,
    input wire logic cs_oen_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    output logic miso_o,
    // behaviour select
    input wire logic good_i,
    input wire logic slow_i
);
    logic [31:0] cmd_addr;
    logic [31:0] word;
    int bit_cnt;
    wire sel = !cs_n_i && !cs_oen_i;
    initial begin
        miso_o = 1'b0;
        bit_cnt = 0;
    end
    always @(negedge sel) begin
        bit_cnt = 0;
    end
    // command and address shift in on the rising clock edge
    always @(posedge sclk_i) begin
        if (sel) begin
            if (bit_cnt < 32) cmd_addr = {cmd_addr[30:0], mosi_i};
            bit_cnt = bit_cnt + 1;
        end
    end
    // signature word only at the signature address
    always @(negedge sclk_i) begin
        if (sel && bit_cnt >= 32 && bit_cnt < 64) begin
            if (bit_cnt == 32) begin
                word = rscd_pkg::ROM_SIG_WORD;
                if (cmd_addr !== {rscd_pkg::ROM_READ_CMD, rscd_pkg::ROM_SIG_ADDR} || !good_i)
                    word = ~word;
            end
            miso_o <= #(slow_i ? 15 : 1) word[63-bit_cnt];
        end
    end
    // released line shows the inverse of its last value
    always @(posedge cs_n_i) begin
        miso_o <= #1 ~miso_o;
    end
endmodule // rscd_rom_model

/* File: dv/rscd_top_tb_top.sv */
// self-checking bench for the reset strap capture and decode block
`timescale 1ns/1ps
module rscd_top_tb_top;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [1:0] dp = 2'h0;
    logic [1:0] cp = 2'h0;
    logic [2:0] fx = 3'h0;
    logic [2:0] ch = 3'h0;
    logic [3:0] pl = 4'h0;
    logic [3:0] mi = 4'h0;
    logic d_low = 1'b0;
    logic c_low = 1'b0;
    logic ext_low = 1'b0;
    logic good = 1'b1;
    logic slow = 1'b0;
    logic cs, cs_oen, d_o, d_oen, c_o, c_oen, miso, h_d, h_c, done, hm, rom_en;
    logic [1:0] stage;
    logic [3:0] p_off, m_off, port_off, ss_off, fixed, charge;
    wire d_pin = ((!d_oen && !d_o) || ext_low) ? 1'b0 : 1'b1;
    wire c_pin = (!c_oen && !c_o) ? 1'b0 : 1'b1;
    int mismatches = 0;
    int check_count = 0;
    always #5 clock_i = ~clock_i;
    rscd_top dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .data_pull_i(dp),
        .clock_pull_i(cp), .fixed_port_count_strap_i(fx), .charging_ports_strap_i(ch),
        .port_plus_line_off_strap_i(pl), .port_minus_line_off_strap_i(mi),
        .rom_serial_in_pin_i(miso), .rom_select_pin_o(cs), .rom_select_pin_oen_o(cs_oen),
        .host_cfg_data_pin_i(d_pin), .host_cfg_data_pin_o(d_o),
        .host_cfg_data_pin_oen_o(d_oen), .host_cfg_clock_pin_i(c_pin),
        .host_cfg_clock_pin_o(c_o), .host_cfg_clock_pin_oen_o(c_oen),
        .host_data_low_i(d_low), .host_clock_low_i(c_low), .host_data_o(h_d),
        .host_clock_o(h_c), .strap_done_o(done), .host_mode_o(hm), .rom_enable_o(rom_en),
        .stage_o(stage), .plus_off_o(p_off), .minus_off_o(m_off), .port_off_o(port_off),
        .ss_port_off_o(ss_off), .fixed_ports_o(fixed), .charge_ports_o(charge));
    rscd_rom_model rom_u (.cs_n_i(cs), .cs_oen_i(cs_oen), .sclk_i(c_o), .mosi_i(d_o),
        .miso_o(miso), .good_i(good), .slow_i(slow));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [3:0] mask_of(input logic [2:0] code);
        case (code)
            3'h1: return 4'h1;
            3'h2: return 4'h3;
            3'h3: return 4'h7;
            3'h4: return 4'hf;
            default: return 4'h0;
        endcase
    endfunction
    task automatic boot(input logic [1:0] d, input logic [1:0] c, input logic [2:0] f,
            input logic [2:0] h, input logic [3:0] p, input logic [3:0] m);
        int n;
        @(posedge clock_i);
        resetn_i <= 1'b0;
        dp <= d;
        cp <= c;
        fx <= f;
        ch <= h;
        pl <= p;
        mi <= m;
        repeat (10) @(posedge clock_i);
        #1;
        chk("done in reset", 4'h0, {3'h0, done});
        chk("masks in reset", 4'h0, fixed | charge | port_off);
        chk("oen in reset", 4'h7, {1'b0, cs_oen, d_oen, c_oen});
        @(posedge clock_i);
        resetn_i <= 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 20) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        if (n >= 20) begin
            mismatches++;
            wrap_up();
        end
        chk("latch edge", 4'h4, n[3:0]);
        chk("port off", p & m, port_off);
        chk("ss port off", p & m, ss_off);
        chk("plus off", p, p_off);
        chk("minus off", m, m_off);
    endtask
    initial begin
        logic [3:0] pulls [4];
        int n;
        pulls = '{4'h0, 4'h0, 4'h4, 4'ha};
        for (int k = 0; k < 8; k++) begin
            boot(2'h1, 2'h1, k[2:0], 3'(7 - k), 4'(k * 5), 4'(k * 3));
            chk("host mode", 4'h1, {3'h0, hm});
            chk("stage", 4'h3, {2'h0, stage});
            chk("fixed", mask_of(k[2:0]), fixed);
            chk("charge", mask_of(3'(7 - k)), charge);
            chk("rom pins off", 4'h7, {1'b0, cs_oen, d_oen, c_oen});
            @(posedge clock_i);
            fx <= ~fx;
            ch <= ~ch;
            pl <= ~pl;
            dp <= 2'h0;
            repeat (8) @(posedge clock_i);
            #1;
            chk("fixed held", mask_of(k[2:0]), fixed);
            chk("port off held", 4'(k * 5) & 4'(k * 3), port_off);
            chk("mode held", 4'h1, {3'h0, hm});
        end
        $display("test host mode decode done");
        @(posedge clock_i);
        d_low <= 1'b1;
        c_low <= 1'b1;
        repeat (5) @(posedge clock_i);
        #1;
        chk("host drives low", 4'h0, {d_oen, c_oen, h_d, h_c});
        @(posedge clock_i);
        d_low <= 1'b0;
        c_low <= 1'b0;
        ext_low <= 1'b1;
        repeat (5) @(posedge clock_i);
        #1;
        chk("host line seen", 4'hd, {d_oen, c_oen, h_d, h_c});
        ext_low <= 1'b0;
        $display("test host pins done");
        for (int s = 0; s < 4; s++) begin
            good <= (s == 0);
            slow <= (s == 1);
            boot(pulls[s][3:2], pulls[s][1:0], 3'h4, 3'h4, 4'h9, 4'h3);
            chk("spi mode", 4'h0, {3'h0, hm});
            chk("spi stage", 4'h1, {2'h0, stage});
            chk("rom pins on", 4'h0, {cs, cs_oen, d_oen, c_oen});
            chk("spi masks", 4'h0, fixed | charge);
            if (s < 2) begin
                n = 0;
                while (stage !== 2'h2 && n < 1000) begin
                    @(posedge clock_i);
                    #1;
                    n++;
                end
                if (n >= 1000) begin
                    mismatches++;
                    wrap_up();
                end
                chk("signature", {3'h0, s == 0}, {3'h0, rom_en});
                chk("rom released", 4'h1, {3'h0, cs});
            end
        end
        $display("test rom mode done");
        wrap_up();
    end
endmodule // rscd_top_tb_top
